// File: fsr_pkg.sv
// Purpose: Shared constants for the security-register, reset, resume and table command block
// Assumes: Serial link sampled on a 125 MHz system clock
// Notes: Resume and suspend counts derive from times in ns; erase, program and reset counts are given in cycles

package fsr_pkg;
   // Opcodes
   localparam logic [7:0] OP_RESUME = 8'h7a;
   localparam logic [7:0] OP_SUSPEND = 8'h75;
   localparam logic [7:0] OP_WRITE_ENABLE_CMD = 8'h06;
   localparam logic [7:0] OP_SEC_ERASE = 8'h44;
   localparam logic [7:0] OP_SEC_PROG = 8'h42;
   localparam logic [7:0] OP_SEC_READ = 8'h48;
   localparam logic [7:0] OP_RST_EN = 8'h66;
   localparam logic [7:0] OP_RST = 8'h99;
   localparam logic [7:0] OP_TBL_READ = 8'h5a;
   // Security register address fields
   localparam logic [3:0] SEC_SEL_1 = 4'h1;
   localparam logic [3:0] SEC_SEL_3 = 4'h3;
   localparam int SEC_BYTES = 512;
   localparam int SEC_PAGES = 4;
   localparam logic [8:0] SEC_LAST = 9'h1ff;
   // Table header values
   localparam logic [7:0] TBL_FILL = 8'hff;
   localparam logic [7:0] TBL_MAKER_ID = 8'h5e; // Arbitrary neutral value
   // Timing
   localparam int CLK_NS = 8;
   localparam int RESUME_NS = 200;
   localparam int RESUME_CYC = RESUME_NS / CLK_NS;
   localparam int SUSPEND_NS = 20000;
   localparam int SUSPEND_CYC = SUSPEND_NS / CLK_NS;
   localparam int ERASE_CYC_DEF = 8000;
   localparam int PROG_CYC_DEF = 5000;
   localparam int RESET_CYC_DEF = 5000;
   // Reset values
   localparam logic [7:0] RST_BYTE = 8'h00;
endpackage : fsr_pkg

// File: fsr_fifo.sv
// Purpose: Small valid/ready FIFO for received data bytes
// Assumes: Single clock
// Notes: Flip-flop storage addressed by index
`timescale 1ns/100ps
`default_nettype none
module fsr_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
) (
   // Clock and reset
   input wire logic mclk_i,
   input wire logic resetn_i,
   input wire logic flush_i,
   // Fill side
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire logic [WIDTH-1:0] in_data_i,
   // Drain side
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [WIDTH-1:0] out_data_o
);
   localparam int AW = $clog2(DEPTH);
   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW-1:0] wp;
      logic [AW-1:0] rp;
      logic [AW:0] cnt;
   } fsr_fifo_t;
   fsr_fifo_t st_r, st_nxt;
   logic push, pop;

   // Handshakes
   assign in_ready_o = (st_r.cnt != (AW+1)'(DEPTH));
   assign out_valid_o = (st_r.cnt != '0);
   assign out_data_o = st_r.mem[st_r.rp];
   assign push = in_valid_i && in_ready_o;
   assign pop = out_valid_o && out_ready_i;

   // Pointer and count update
   always_comb begin
      st_nxt = st_r;
      if (push) begin
         st_nxt.mem[st_r.wp] = in_data_i;
         st_nxt.wp = st_r.wp + 1'b1;
      end
      if (pop) begin
         st_nxt.rp = st_r.rp + 1'b1;
      end
      st_nxt.cnt = st_r.cnt + (AW+1)'(push) - (AW+1)'(pop);
      if (flush_i) begin
         st_nxt.wp = '0;
         st_nxt.rp = '0;
         st_nxt.cnt = '0;
      end
   end

   // State register
   always_ff @(posedge mclk_i) begin
      if (!resetn_i) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end
endmodule // fsr_fifo
`default_nettype wire

// File: fsr_cmd.sv
// Purpose: Serial command interpreter for resume, security registers, software reset and table header
// Assumes: Serial clock, select and data pins are sampled by mclk_i through two flip-flops
// Notes: Single-bit serial mode only; link clock period far above system clock
// Summary of operation
// - Resume taken only when suspended and not busy, else ignored
// - Resume clears suspend at once, raises busy within 200 ns, finishes the job
// - Suspend sets suspend flag at once, clears busy within suspend time
// - Three 512-byte security registers, each erased and programmed alone
// - Security erase or program refused while write enable latch is clear
// - Erase is opcode plus three address bytes, select rises on byte boundary
// - Valid erase starts timed cycle, busy held, latch cleared before end
// - Lock bit set makes security erase ignored
// - Register chosen by address bits 15..12, other high bits zero
// - Each security register is four program pages
// - Program starts timed cycle with busy, latch cleared before end
// - Lock bit set makes security program ignored
// - Security read is opcode, address, dummy byte, data on falling edges
// - Read address increments and wraps within 512 bytes
// - Reset needs enable-reset frame then reset frame
// - Accepted reset aborts operation and clears volatile state
// - Commands rejected during reset recovery time
// - Table header starts with signature and revision 1.0
// - Header count reads one, unused bytes read all ones
// - First header: ID zero, revision 1.0, nine dwords, pointer 30h
// - Second header: maker ID, revision 1.0, three dwords, pointer 60h
`timescale 1ns/100ps
`default_nettype none
module fsr_cmd
   import fsr_pkg::*;
#(
   parameter int ERASE_CYC = ERASE_CYC_DEF,
   parameter int PROG_CYC = PROG_CYC_DEF,
   parameter int RESET_CYC = RESET_CYC_DEF
) (
   // Clock and reset
   input wire logic mclk_i,
   input wire logic resetn_i,
   // Serial pins
   input wire logic cs_n_i,
   input wire logic sclk_i,
   input wire logic si_i,
   output logic so_o,
   output logic so_oe_n_o,
   // Status and configuration
   input wire logic [2:0] security_lock_bits_i,
   input wire logic array_suspend_i,
   output logic write_in_progress_o,
   output logic write_enable_latch_o,
   output logic suspended_flag_o,
   output logic reset_busy_o,
   output logic soft_reset_o
);
   typedef enum logic [2:0] {S_OP, S_ADDR, S_DUMMY, S_DOUT, S_DIN, S_SKIP} fsr_ph_t;
   typedef enum logic [1:0] {J_IDLE, J_ERASE, J_PROG} fsr_job_t;
   typedef struct packed {
      logic [2:0] cs_s, ck_s, si_s;
      fsr_ph_t ph;
      logic [7:0] op;
      logic [7:0] sh;
      logic [2:0] bit_n;
      logic [1:0] abyte;
      logic [23:0] addr;
      logic got_data;
      logic [7:0] dout;
      logic so;
      logic oe_n;
      logic write_in_progress, write_enable_latch, suspended_flag, rst_armed, rst_pulse;
      fsr_job_t job, sus_job;
      logic [12:0] tmr;
      logic [12:0] rtmr;
      logic [12:0] stmr;
      logic [1:0] pg_sel;
      logic [8:0] pg_base;
   } fsr_st_t;
   fsr_st_t st_r, st_nxt;
   logic [2:0][SEC_BYTES-1:0][7:0] sec_mem_r;
   logic ck_rise, ck_fall, cs_rise, cs_fall, cs_n, rec_busy;
   logic fifo_valid, fifo_ready, fifo_flush, fifo_pop;
   logic [7:0] fifo_data;
   logic [1:0] sec_idx;

   // Table header byte lookup
   function automatic logic [7:0] tbl_byte(input logic [7:0] a);
      logic [7:0] v;
      v = TBL_FILL;
      unique case (a)
         8'h00: v = 8'h53;
         8'h01: v = 8'h46;
         8'h02: v = 8'h44;
         8'h03: v = 8'h50;
         8'h04: v = 8'h00;
         8'h05: v = 8'h01;
         8'h06: v = 8'h01;
         8'h08: v = 8'h00;
         8'h09: v = 8'h00;
         8'h0a: v = 8'h01;
         8'h0b: v = 8'h09;
         8'h0c: v = 8'h30;
         8'h0d, 8'h0e: v = 8'h00;
         8'h10: v = TBL_MAKER_ID;
         8'h11: v = 8'h00;
         8'h12: v = 8'h01;
         8'h13: v = 8'h03;
         8'h14: v = 8'h60;
         8'h15, 8'h16: v = 8'h00;
         default: v = TBL_FILL;
      endcase
      return v;
   endfunction

   // Security register address check, erase ignores low bits
   function automatic logic sec_ok(input logic [23:0] a);
      return a[23:16] == 8'h00 && a[11:9] == 3'h0 && a[15:12] >= SEC_SEL_1 && a[15:12] <= SEC_SEL_3;
   endfunction

   // Edge detection on synchronised pins
   assign cs_n = st_r.cs_s[1];
   assign ck_rise = st_r.ck_s[1] && !st_r.ck_s[2];
   assign ck_fall = !st_r.ck_s[1] && st_r.ck_s[2];
   assign cs_rise = st_r.cs_s[1] && !st_r.cs_s[2];
   assign cs_fall = !st_r.cs_s[1] && st_r.cs_s[2];
   assign rec_busy = st_r.rtmr != '0;
   assign sec_idx = 2'(st_r.addr[15:12] - 4'h1);
   // Bytes drain into the page only while the timed program runs
   assign fifo_pop = fifo_valid && st_r.job == J_PROG && !st_r.suspended_flag;

   // Data byte buffer between serial input and programming
   fsr_fifo #(.WIDTH(8), .DEPTH(8)) u_fifo (
      .mclk_i(mclk_i),
      .resetn_i(resetn_i),
      .flush_i(fifo_flush),
      .in_valid_i(st_r.ph == S_DIN && ck_rise && st_r.bit_n == 3'h7),
      .in_ready_o(fifo_ready),
      .in_data_i({st_r.sh[6:0], st_r.si_s[1]}),
      .out_valid_o(fifo_valid),
      .out_ready_i(fifo_pop),
      .out_data_o(fifo_data)
   );

   // Serial decode and operation control
   always_comb begin
      logic [7:0] byte_in;
      logic [8:0] nxt_lo;
      byte_in = {st_r.sh[6:0], st_r.si_s[1]};
      nxt_lo = (st_r.addr[8:0] == SEC_LAST) ? 9'h000 : st_r.addr[8:0] + 9'h001;
      st_nxt = st_r;
      fifo_flush = 1'b0;
      st_nxt.cs_s = {st_r.cs_s[1:0], cs_n_i};
      st_nxt.ck_s = {st_r.ck_s[1:0], sclk_i};
      st_nxt.si_s = {st_r.si_s[1:0], si_i};
      st_nxt.rst_pulse = 1'b0;
      if (st_r.rtmr != '0) st_nxt.rtmr = st_r.rtmr - 1'b1;
      // Job timers
      if (st_r.stmr != '0) begin
         st_nxt.stmr = st_r.stmr - 1'b1;
         if (st_r.stmr == 13'd1) st_nxt.write_in_progress = 1'b0;
      end
      if (st_r.job != J_IDLE && !st_r.suspended_flag) begin
         if (st_r.tmr != '0) st_nxt.tmr = st_r.tmr - 1'b1;
         if (st_r.tmr == 13'd2) st_nxt.write_enable_latch = 1'b0;
         if (st_r.tmr == 13'd1) begin
            st_nxt.write_in_progress = 1'b0;
            st_nxt.job = J_IDLE;
         end
         if (st_r.job == J_ERASE && st_r.tmr == 13'd1) fifo_flush = 1'b1;
      end
      if (cs_fall) begin
         st_nxt.ph = S_OP;
         st_nxt.bit_n = '0;
         st_nxt.abyte = '0;
         st_nxt.got_data = 1'b0;
      end
      if (!cs_n && ck_rise) begin
         st_nxt.sh = byte_in;
         st_nxt.bit_n = st_r.bit_n + 1'b1;
         if (st_r.bit_n == 3'h7) begin
            unique case (st_r.ph)
               S_OP: begin
                  st_nxt.op = byte_in;
                  st_nxt.ph = S_SKIP;
                  if (!rec_busy && (byte_in == OP_SEC_ERASE || byte_in == OP_SEC_PROG ||
                      byte_in == OP_SEC_READ || byte_in == OP_TBL_READ)) st_nxt.ph = S_ADDR;
               end
               S_ADDR: begin
                  st_nxt.addr = {st_r.addr[15:0], byte_in};
                  st_nxt.abyte = st_r.abyte + 1'b1;
                  if (st_r.abyte == 2'd2) begin
                     if (st_r.op == OP_SEC_READ || st_r.op == OP_TBL_READ) st_nxt.ph = S_DUMMY;
                     else if (st_r.op == OP_SEC_PROG) st_nxt.ph = S_DIN;
                     else st_nxt.ph = S_SKIP;
                  end
               end
               S_DUMMY: begin
                  st_nxt.ph = S_DOUT;
                  st_nxt.dout = (st_r.op == OP_SEC_READ) ? sec_mem_r[sec_idx][st_r.addr[8:0]] :
                                tbl_byte(st_r.addr[7:0]);
               end
               S_DIN: begin
                  st_nxt.got_data = 1'b1;
                  if (!st_r.got_data) st_nxt.pg_base = {st_r.addr[8:8], st_r.addr[7:0]};
               end
               default: ;
            endcase
         end
         if (st_r.ph == S_DOUT && st_r.bit_n == 3'h7) begin
            // Address advance and wrap inside the register
            st_nxt.addr[8:0] = nxt_lo;
            // Next byte ready before the first falling edge of its slot
            st_nxt.dout = (st_r.op == OP_SEC_READ) ? sec_mem_r[sec_idx][nxt_lo] : tbl_byte(nxt_lo[7:0]);
            if (st_r.op == OP_TBL_READ) st_nxt.addr[23:9] = st_r.addr[23:9] + {14'h0, &st_r.addr[8:0]};
         end
      end
      if (st_r.ph == S_DOUT && ck_rise && st_r.bit_n == 3'h0) begin
         st_nxt.dout = (st_r.op == OP_SEC_READ) ? sec_mem_r[sec_idx][st_r.addr[8:0]] : tbl_byte(st_r.addr[7:0]);
      end
      // Output on falling edges
      if (!cs_n && ck_fall && st_r.ph == S_DOUT) begin
         st_nxt.so = st_r.dout[3'h7 - st_r.bit_n];
         st_nxt.oe_n = 1'b0;
      end
      // Page offset steps with each stored byte
      if (fifo_pop) st_nxt.addr[6:0] = st_r.addr[6:0] + 7'h01;
      // Frame end decides execution
      if (cs_rise) begin
         st_nxt.ph = S_OP;
         st_nxt.oe_n = 1'b1;
         st_nxt.so = 1'b0;
         if (!rec_busy && st_r.bit_n == 3'h0) begin
            if (st_r.ph == S_SKIP && st_r.op == OP_WRITE_ENABLE_CMD && !st_r.write_in_progress) st_nxt.write_enable_latch = 1'b1;
            if (st_r.ph == S_SKIP && st_r.op == OP_RESUME && st_r.suspended_flag && !st_r.write_in_progress) begin
               st_nxt.suspended_flag = 1'b0;
               st_nxt.write_in_progress = 1'b1;
            end
            if (st_r.ph == S_SKIP && st_r.op == OP_SUSPEND && !st_r.suspended_flag && st_r.write_in_progress && array_suspend_i) begin
               st_nxt.suspended_flag = 1'b1;
               st_nxt.sus_job = (st_r.job == J_PROG) ? J_PROG : J_ERASE;
               st_nxt.stmr = 13'(SUSPEND_CYC);
            end
            // Erase executes only on an exact byte boundary after three address bytes
            if (st_r.ph == S_SKIP && st_r.op == OP_SEC_ERASE && st_r.abyte == 2'd3 && st_r.write_enable_latch &&
                !st_r.write_in_progress && !st_r.suspended_flag && security_lock_bits_i == 3'h0 && sec_ok(st_r.addr)) begin
               st_nxt.job = J_ERASE;
               st_nxt.write_in_progress = 1'b1;
               st_nxt.tmr = 13'(ERASE_CYC);
            end
            if (st_r.ph == S_DIN && st_r.got_data && st_r.write_enable_latch && !st_r.write_in_progress && !st_r.suspended_flag &&
                security_lock_bits_i == 3'h0 && sec_ok(st_r.addr)) begin
               st_nxt.job = J_PROG;
               st_nxt.write_in_progress = 1'b1;
               st_nxt.tmr = 13'(PROG_CYC);
            end else if (st_r.ph == S_DIN) begin
               fifo_flush = 1'b1;
            end
            if (st_r.ph == S_SKIP && st_r.op == OP_RST_EN) st_nxt.rst_armed = 1'b1;
            else if (st_r.ph == S_SKIP && st_r.op == OP_RST && st_r.rst_armed) begin
               st_nxt.rst_armed = 1'b0;
               st_nxt.write_in_progress = 1'b0;
               st_nxt.write_enable_latch = 1'b0;
               st_nxt.suspended_flag = 1'b0;
               st_nxt.job = J_IDLE;
               st_nxt.tmr = '0;
               st_nxt.stmr = '0;
               st_nxt.rtmr = 13'(RESET_CYC);
               st_nxt.rst_pulse = 1'b1;
               fifo_flush = 1'b1;
            end else st_nxt.rst_armed = 1'b0;
         end else st_nxt.rst_armed = 1'b0;
         // Refused or cut program frames leave no bytes behind
         if (st_r.ph == S_DIN && !(st_nxt.job == J_PROG && st_r.job != J_PROG)) fifo_flush = 1'b1;
      end
   end

   // State register
   always_ff @(posedge mclk_i) begin
      if (!resetn_i) begin
         st_r <= '0;
         st_r.cs_s <= 3'h7;
         st_r.oe_n <= 1'b1;
      end else begin
         st_r <= st_nxt;
      end
   end

   // Security register storage, erase sets ones, program clears bits within a page
   always_ff @(posedge mclk_i) begin
      if (!resetn_i) begin
         sec_mem_r <= '1;
      end else if (st_r.job == J_ERASE && st_r.tmr == 13'd1 && !st_r.suspended_flag) begin
         sec_mem_r[sec_idx] <= '1;
      end else if (fifo_pop && sec_ok(st_r.addr)) begin
         sec_mem_r[sec_idx][{st_r.pg_base[8:7], st_r.addr[6:0]}] <=
            sec_mem_r[sec_idx][{st_r.pg_base[8:7], st_r.addr[6:0]}] & fifo_data;
      end
   end

   // Status outputs
   assign so_o = st_r.so;
   assign so_oe_n_o = st_r.oe_n;
   assign write_in_progress_o = st_r.write_in_progress;
   assign write_enable_latch_o = st_r.write_enable_latch;
   assign suspended_flag_o = st_r.suspended_flag;
   assign reset_busy_o = rec_busy;
   assign soft_reset_o = st_r.rst_pulse;

   // Resume raises busy inside the time bound
   property p_resume_busy;
      @(posedge mclk_i) disable iff (!resetn_i)
      (cs_rise && st_r.op == OP_RESUME && st_r.ph == S_SKIP && st_r.suspended_flag && !st_r.write_in_progress && st_r.bit_n == 3'h0 && !rec_busy)
      |=> !st_r.suspended_flag ##[0:25] st_r.write_in_progress;
   endproperty
   a_resume_busy: assert property (p_resume_busy) else $error("resume did not raise busy");

   // Resume ignored unless suspended
   property p_resume_ign;
      @(posedge mclk_i) disable iff (!resetn_i)
      (cs_rise && st_r.op == OP_RESUME && !st_r.suspended_flag) |=> st_r.job == $past(st_r.job);
   endproperty
   a_resume_ign: assert property (p_resume_ign) else $error("resume taken while not suspended");

   // Erase refused without latch
   property p_no_wel;
      @(posedge mclk_i) disable iff (!resetn_i)
      (cs_rise && !st_r.write_enable_latch && !st_r.write_in_progress && st_r.op != OP_RESUME) |=> !st_r.write_in_progress;
   endproperty
   a_no_wel: assert property (p_no_wel) else $error("program or erase ran without latch");

   // Lock bits block work
   property p_locked;
      @(posedge mclk_i) disable iff (!resetn_i)
      (cs_rise && security_lock_bits_i != 3'h0 && !st_r.write_in_progress && st_r.op != OP_RESUME) |=> !st_r.write_in_progress;
   endproperty
   a_locked: assert property (p_locked) else $error("locked register was changed");

   // Reset clears volatile status
   sequence s_rst_taken;
      st_r.rst_pulse;
   endsequence
   property p_reset_clear;
      @(posedge mclk_i) disable iff (!resetn_i)
      s_rst_taken |-> !st_r.write_in_progress && !st_r.write_enable_latch && !st_r.suspended_flag && rec_busy;
   endproperty
   a_reset_clear: assert property (p_reset_clear) else $error("reset left state behind");

   // Latch drops before busy ends
   property p_wel_first;
      @(posedge mclk_i) disable iff (!resetn_i)
      $fell(st_r.write_in_progress) && !st_r.suspended_flag |-> !st_r.write_enable_latch;
   endproperty
   a_wel_first: assert property (p_wel_first) else $error("latch still set after cycle");

   // Output released when select rises
   property p_release;
      @(posedge mclk_i) disable iff (!resetn_i)
      cs_rise |=> so_oe_n_o;
   endproperty
   a_release: assert property (p_release) else $error("output still driven after select rise");

   // Suspend sets flag and loads the suspend timer
   property p_suspend;
      @(posedge mclk_i) disable iff (!resetn_i)
      $rose(st_r.suspended_flag) |-> st_r.stmr == 13'(SUSPEND_CYC);
   endproperty
   a_suspend: assert property (p_suspend) else $error("suspend timer not loaded");
endmodule // fsr_cmd
`default_nettype wire

// File: fsr_host.sv
// Purpose: Host serial controller model driving select, clock and data in
// Assumes: 125 MHz system clock, serial clock of 160 ns built from it
// Notes: Serial clock rests low between frames; data in toggles once released
`timescale 1ns/100ps
`default_nettype none
module fsr_host (
   // System clock
   input wire logic mclk_i,
   // Serial pins
   output logic cs_n_o,
   output logic sclk_o,
   output logic si_o,
   input wire logic so_i
);
   // Idle pin levels
   initial begin
      cs_n_o = 1'b1;
      sclk_o = 1'b0;
      si_o = 1'b0;
   end

   // Whole clocks, then step just past the edge
   task automatic tick(input int n);
      repeat (n) @(posedge mclk_i);
      #1;
   endtask

   // One frame: whole bytes out, optional stray bits, then bytes read back
   task automatic frame(input logic [7:0] tx[$], input int bits, input int nrd, output logic [7:0] rx[$]);
      logic [7:0] sh;
      logic [7:0] acc;
      int base;
      rx = {};
      acc = 8'h00;
      base = tx.size() * 8 + bits;
      cs_n_o = 1'b0;
      tick(10);
      for (int i = 0; i < base + nrd * 8; i++) begin
         sh = (i / 8 < tx.size()) ? tx[i / 8] : 8'h00;
         si_o = sh[7 - i % 8];
         tick(10);
         sclk_o = 1'b1;
         acc = {acc[6:0], so_i};
         if (i >= base && (i - base) % 8 == 7) begin
            rx.push_back(acc);
         end
         tick(10);
         sclk_o = 1'b0;
      end
      // Released data line shows the inverse of its last value
      si_o = ~si_o;
      tick(5);
      cs_n_o = 1'b1;
      tick(20);
   endtask
endmodule // fsr_host
`default_nettype wire

// File: tb_flash_secreg_reset_sfdp_cmds.sv
// Purpose: Self-checking bench for the command block
// Assumes: Shortened cycle counts through parameters
// Notes: Expected security contents kept in a local model
`timescale 1ns/100ps
`default_nettype none
module tb_flash_secreg_reset_sfdp_cmds;
   import fsr_pkg::*;
   localparam int ERASE_N = 400;
   localparam int PROG_N = 2000;
   localparam int RESET_N = 300;
   localparam logic [7:0] HDR [24] = '{8'h53, 8'h46, 8'h44, 8'h50, 8'h00, 8'h01, 8'h01, 8'hff, 8'h00, 8'h00,
      8'h01, 8'h09, 8'h30, 8'h00, 8'h00, 8'hff, TBL_MAKER_ID, 8'h00, 8'h01, 8'h03, 8'h60, 8'h00, 8'h00, 8'hff};
   logic mclk_i, resetn_i, cs_n, sclk, si, so, so_oe_n, susp_ok;
   logic write_in_progress, write_enable_latch, susp, rbusy, srst;
   logic [2:0] lock;
   logic [7:0] rx[$];
   logic [7:0] mem [1:3][0:511];
   logic [8:0] off;
   logic [31:0] seed = 32'h518e6909;
   int mismatches = 0;
   int compares = 0;
   int pulses = 0;

   // Design and host model
   fsr_cmd #(.ERASE_CYC(ERASE_N), .PROG_CYC(PROG_N), .RESET_CYC(RESET_N)) i_dut (.mclk_i(mclk_i),
      .resetn_i(resetn_i), .cs_n_i(cs_n), .sclk_i(sclk), .si_i(si), .so_o(so), .so_oe_n_o(so_oe_n),
      .security_lock_bits_i(lock), .array_suspend_i(susp_ok), .write_in_progress_o(write_in_progress),
      .write_enable_latch_o(write_enable_latch), .suspended_flag_o(susp), .reset_busy_o(rbusy), .soft_reset_o(srst));
   fsr_host i_host (.mclk_i(mclk_i), .cs_n_o(cs_n), .sclk_o(sclk), .si_o(si), .so_i(so));

   // System clock
   initial begin
      mclk_i = 1'b0;
      forever #4 mclk_i = ~mclk_i;
   end
   // Count reset pulses
   always @(posedge mclk_i) begin
      if (srst === 1'b1) begin
         pulses++;
      end
   end

   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         mismatches++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic wrap_up();
      $display("counts: compares=%0d mismatches=%0d", compares, mismatches);
      if (mismatches == 0 && compares > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   // Bounded wait on busy (0), reset recovery (1) or suspend (2)
   task automatic wait_for(input int sel, input logic lvl, input int bound);
      logic v;
      for (int n = 0; n <= bound; n++) begin
         v = (sel == 0) ? write_in_progress : (sel == 1) ? rbusy : susp;
         if (v === lvl) begin
            return;
         end
         i_host.tick(1);
      end
      mismatches++;
      wrap_up();
   endtask

   task automatic cmd(input logic [7:0] op);
      i_host.frame('{op}, 0, 0, rx);
   endtask

   task automatic sec_read(input logic [3:0] sel, input logic [8:0] a, input int n);
      i_host.frame('{OP_SEC_READ, 8'h00, {sel, 3'b000, a[8]}, a[7:0], 8'h00}, 0, n, rx);
      for (int i = 0; i < n; i++) begin
         check(rx[i], mem[sel][a + 9'(i)]);
      end
   endtask

   task automatic do_prog(input logic [3:0] sel, input logic [8:0] a, input int n, input bit fin);
      logic [7:0] q[$];
      logic [7:0] d;
      q = '{OP_SEC_PROG, 8'h00, {sel, 3'b000, a[8]}, a[7:0]};
      cmd(OP_WRITE_ENABLE_CMD);
      for (int i = 0; i < n; i++) begin
         d = 8'(rnd());
         q.push_back(d);
         if (lock == 3'b000) begin
            mem[sel][{a[8:7], a[6:0] + 7'(i)}] &= d;
         end
      end
      i_host.frame(q, 0, 0, rx);
      check(write_in_progress, lock == 3'b000);
      if (fin && lock == 3'b000) begin
         wait_for(0, 1'b0, PROG_N + 20);
         check(write_enable_latch, 1'b0);
      end
   endtask

   task automatic do_erase(input logic [3:0] sel, input int bits);
      cmd(OP_WRITE_ENABLE_CMD);
      i_host.frame('{OP_SEC_ERASE, 8'h00, {sel, 4'h0}, 8'h00}, bits, 0, rx);
      check(write_in_progress, lock == 3'b000 && bits == 0);
      if (lock == 3'b000 && bits == 0) begin
         wait_for(0, 1'b0, ERASE_N + 20);
         check(write_enable_latch, 1'b0);
         foreach (mem[sel][i]) mem[sel][i] = 8'hff;
      end
   endtask

   // Timeout guard
   initial begin
      repeat (90000) @(posedge mclk_i);
      mismatches++;
      wrap_up();
   end

   // Main sequence
   initial begin
      resetn_i = 1'b0;
      lock = 3'b000;
      susp_ok = 1'b1;
      foreach (mem[s, i]) mem[s][i] = 8'hff;
      i_host.tick(12);
      resetn_i = 1'b1;
      i_host.tick(5);
      i_host.frame('{OP_TBL_READ, 8'h00, 8'h00, 8'h00, 8'h00}, 0, 24, rx);
      foreach (HDR[i]) check(rx[i], HDR[i]);
      i_host.frame('{OP_SEC_READ, 8'h00}, 3, 0, rx);
      check({write_in_progress, write_enable_latch}, 2'b00);
      i_host.frame('{OP_SEC_ERASE, 8'h00, 8'h20, 8'h00}, 0, 0, rx);
      check(write_in_progress, 1'b0);
      $display("test table and refusals done");
      off = 9'(rnd());
      do_prog(4'h2, off, 1 + rnd() % 4, 1'b1);
      sec_read(4'h2, off, 4);
      do_prog(4'h3, 9'h1fe, 3, 1'b1);
      sec_read(4'h3, 9'h1fe, 3);
      do_erase(4'h2, 0);
      sec_read(4'h2, off, 2);
      sec_read(4'h3, 9'h1fe, 2);
      do_erase(4'h3, 3);
      $display("test program erase done");
      lock = 3'(1 << (rnd() % 3));
      do_erase(4'h3, 0);
      do_prog(4'h3, 9'h000, 1, 1'b1);
      sec_read(4'h3, 9'h1fe, 2);
      lock = 3'b000;
      $display("test lock done");
      cmd(OP_RESUME);
      check({susp, write_in_progress}, 2'b00);
      do_prog(4'h1, 9'h000, 1, 1'b0);
      cmd(OP_SUSPEND);
      check(susp, 1'b1);
      wait_for(0, 1'b0, SUSPEND_CYC + 10);
      cmd(OP_RESUME);
      check(susp, 1'b0);
      wait_for(0, 1'b1, 15);
      wait_for(0, 1'b0, PROG_N + 20);
      sec_read(4'h1, 9'h000, 1);
      $display("test resume done");
      check({susp, write_in_progress}, 2'b00);
      cmd(OP_WRITE_ENABLE_CMD);
      cmd(OP_RST);
      check(pulses, 0);
      check(write_enable_latch, 1'b1);
      cmd(OP_RST_EN);
      cmd(OP_RST);
      check(pulses, 1);
      check({write_enable_latch, rbusy}, 2'b01);
      cmd(OP_WRITE_ENABLE_CMD);
      check(write_enable_latch, 1'b0);
      wait_for(1, 1'b0, RESET_N + 20);
      cmd(OP_WRITE_ENABLE_CMD);
      check(write_enable_latch, 1'b1);
      $display("test reset done");
      wrap_up();
   end
endmodule // tb_flash_secreg_reset_sfdp_cmds
`default_nettype wire
